// File: verilog/rwdt_runaway_detector.sv
// Runaway watchdog: 22-stage counter, APB registers, overflow NMI and forced reset
// What this block does
// R1: Twenty-two stage binary counter on the system clock counts while running.
// R2: Period select picks overflow at clock over 2^15, 2^17, 2^19 or 2^21.
// R3: Elapsed period without a clear raises the overflow interrupt.
// R4: Overflow interrupt is non-maskable; no mask exists here.
// R5: Software writes the clear code before the period runs out.
// R6: Clear code resets the counter to zero; counting resumes.
// R7: Period select resets to 00, the shortest period.
// R8: Watchdog runs straight after reset, enable bit resets to one.
// R9: Disable only by enable bit at zero, then the disable code.
// R10: Writing the enable bit to one alone re-enables the watchdog.
// R11: Software writes the clear code once before the disable code.
// R12: Software disables the watchdog before changing its settings.
// R13: Reset-link bit routes overflow to the internal reset output.
// R14: Reset-link bit resets to zero, no forced reset by default.
// R15: Forced reset lasts 653 peripheral clock cycles, at least 26100 ns.
// R16: Counter halts in light idle and stop modes.
// R17: Counter keeps counting while the bus is released.
// R18: In partial idle the partial_idle_mode-run bit decides run or halt.
// R19: Other command codes change neither counter nor enable state.
// R20: Chip reset clears the counter to zero.
`timescale 1ns/100ps
module rwdt_runaway_detector
#(
    parameter int unsigned TAP_EXP0 = rwdt_pkg::TAP_EXP0,
    parameter int unsigned TAP_EXP1 = rwdt_pkg::TAP_EXP1,
    parameter int unsigned TAP_EXP2 = rwdt_pkg::TAP_EXP2,
    parameter int unsigned TAP_EXP3 = rwdt_pkg::TAP_EXP3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rwdt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rwdt_pkg::rwdt_power_type power,
    output logic overflow_irq,
    output logic internal_reset_req
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [rwdt_pkg::CNT_W-1:0] cnt;
        rwdt_pkg::rwdt_mode_type mode;
        logic disabled;
        logic irq;
        logic [31:0] rdata;
    } rwdt_state_type;

    rwdt_state_type st_ff;
    rwdt_state_type nxt_st;

    logic [rwdt_pkg::CNT_W-1:0] tap_mask;
    logic [rwdt_pkg::CNT_W:0] wide_mask;
    int unsigned tap_exp;
    logic running;
    logic overflow;
    logic access;
    logic wr_mode;
    logic wr_cmd;
    logic mapped;
    logic [7:0] cmd_code;
    logic reset_active;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign access = psel && penable;
    assign mapped = (paddr == rwdt_pkg::ADDR_MODE) || (paddr == rwdt_pkg::ADDR_CMD)
                    || (paddr == rwdt_pkg::ADDR_STAT);
    assign wr_mode = access && pwrite && (paddr == rwdt_pkg::ADDR_MODE);
    assign wr_cmd = access && pwrite && (paddr == rwdt_pkg::ADDR_CMD);
    assign cmd_code = pwdata[7:0];
    // Zero wait states: read data is captured during setup
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ------------------------------------------------------------
    // Tap selection
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (st_ff.mode.period_sel)
            2'h0: tap_exp = TAP_EXP0; // R2
            2'h1: tap_exp = TAP_EXP1;
            2'h2: tap_exp = TAP_EXP2;
            2'h3: tap_exp = TAP_EXP3;
        endcase
        wide_mask = ((rwdt_pkg::CNT_W + 1)'(1) << tap_exp) - (rwdt_pkg::CNT_W + 1)'(1);
        tap_mask = wide_mask[rwdt_pkg::CNT_W-1:0];
    end

    // ------------------------------------------------------------
    // Run condition
    // ------------------------------------------------------------
    // Bus release does not appear here on purpose: the counter keeps going
    always_comb
    begin
        running = !st_ff.disabled; // R1
        if (power.stop_mode || power.light_idle_mode)
            running = 1'b0; // R16
        if (power.partial_idle_mode && !st_ff.mode.partial_idle_mode_run)
            running = 1'b0; // R18
    end

    assign overflow = running && ((st_ff.cnt & tap_mask) == tap_mask); // R3

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.irq = overflow; // R3 R4
        if (wr_cmd && cmd_code == rwdt_pkg::CODE_CLEAR)
            nxt_st.cnt = '0; // R6
        else if (overflow)
            nxt_st.cnt = '0;
        else if (running)
            nxt_st.cnt = st_ff.cnt + 1'b1; // R1 R17

        if (wr_cmd && cmd_code == rwdt_pkg::CODE_DISABLE && !st_ff.mode.enable)
            nxt_st.disabled = 1'b1; // R9
        // Any other code falls through untouched R19

        if (wr_mode)
        begin
            nxt_st.mode.enable = pwdata[rwdt_pkg::MODE_EN_BIT];
            nxt_st.mode.period_sel = pwdata[rwdt_pkg::MODE_PSEL_LSB +: 2];
            nxt_st.mode.partial_idle_mode_run = pwdata[rwdt_pkg::MODE_I2_BIT];
            nxt_st.mode.reset_link = pwdata[rwdt_pkg::MODE_LINK_BIT];
            if (pwdata[rwdt_pkg::MODE_EN_BIT])
                nxt_st.disabled = 1'b0; // R10
        end

        if (psel && !penable && !pwrite)
        begin
            nxt_st.rdata = '0;
            if (paddr == rwdt_pkg::ADDR_MODE)
            begin
                nxt_st.rdata[rwdt_pkg::MODE_EN_BIT] = st_ff.mode.enable;
                nxt_st.rdata[rwdt_pkg::MODE_PSEL_LSB +: 2] = st_ff.mode.period_sel;
                nxt_st.rdata[rwdt_pkg::MODE_I2_BIT] = st_ff.mode.partial_idle_mode_run;
                nxt_st.rdata[rwdt_pkg::MODE_LINK_BIT] = st_ff.mode.reset_link;
            end
            else if (paddr == rwdt_pkg::ADDR_STAT)
            begin
                nxt_st.rdata[rwdt_pkg::STAT_RUN_BIT] = running;
                nxt_st.rdata[rwdt_pkg::STAT_DIS_BIT] = st_ff.disabled;
                nxt_st.rdata[rwdt_pkg::STAT_RST_BIT] = reset_active;
                nxt_st.rdata[rwdt_pkg::STAT_BUS_RELEASE_ACK_BIT] = power.bus_release_ack_n;
                nxt_st.rdata[rwdt_pkg::STAT_CNT_LSB +: rwdt_pkg::CNT_W] = st_ff.cnt;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff.cnt <= '0; // R20
            st_ff.mode.enable <= rwdt_pkg::RST_EN; // R8
            st_ff.mode.period_sel <= rwdt_pkg::RST_PSEL; // R7
            st_ff.mode.partial_idle_mode_run <= rwdt_pkg::RST_I2;
            st_ff.mode.reset_link <= rwdt_pkg::RST_LINK; // R14
            st_ff.disabled <= 1'b0;
            st_ff.irq <= 1'b0;
            st_ff.rdata <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign overflow_irq = st_ff.irq;
    assign prdata = st_ff.rdata;

    // ------------------------------------------------------------
    // Forced reset
    // ------------------------------------------------------------
    // Only the device reset is driven; the external pin is left alone
    rwdt_reset_stretch i_rwdt_reset_stretch
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(overflow && st_ff.mode.reset_link), // R13
        .pulse_out(reset_active)
    );

    assign internal_reset_req = reset_active;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cmd(logic [7:0] code);
        wr_cmd && cmd_code == code;
    endsequence

    property p_clear_zero;
        s_cmd(rwdt_pkg::CODE_CLEAR) |=> st_ff.cnt == '0;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear code left counter nonzero"); // R6

    property p_irq_cause;
        overflow_irq |-> $past(running) && (($past(st_ff.cnt) & $past(tap_mask)) == $past(tap_mask));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without elapsed period"); // R2

    property p_irq_follows;
        overflow |=> overflow_irq ##1 !overflow_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("overflow did not pulse irq"); // R3

    property p_disable;
        s_cmd(rwdt_pkg::CODE_DISABLE) ##0 (!st_ff.mode.enable && !wr_mode) |=> st_ff.disabled && !running;
    endproperty
    a_disable: assert property (p_disable) else $error("disable sequence failed"); // R9

    property p_no_disable_enabled;
        st_ff.mode.enable |=> !st_ff.disabled;
    endproperty
    a_no_disable_enabled: assert property (p_no_disable_enabled) else $error("disabled while enabled"); // R9

    property p_other_code;
        wr_cmd && cmd_code != rwdt_pkg::CODE_CLEAR && cmd_code != rwdt_pkg::CODE_DISABLE
        |=> (st_ff.disabled == $past(st_ff.disabled) && st_ff.cnt != '0) || $past(overflow);
    endproperty
    a_other_code: assert property (p_other_code) else $error("foreign code had an effect"); // R19

    property p_reenable;
        wr_mode && pwdata[rwdt_pkg::MODE_EN_BIT] |=> !st_ff.disabled;
    endproperty
    a_reenable: assert property (p_reenable) else $error("enable bit did not re-enable"); // R10

    property p_reset_link;
        overflow_irq && $past(st_ff.mode.reset_link) && !$past(reset_active) |-> internal_reset_req;
    endproperty
    a_reset_link: assert property (p_reset_link) else $error("linked overflow gave no reset"); // R13

    property p_no_link;
        !internal_reset_req && !st_ff.mode.reset_link |=> !internal_reset_req;
    endproperty
    a_no_link: assert property (p_no_link) else $error("reset without link bit"); // R13

    property p_halt;
        (power.stop_mode || power.light_idle_mode) && !wr_cmd |=> st_ff.cnt == $past(st_ff.cnt);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved in halt mode"); // R16

    property p_partial_idle_mode;
        power.partial_idle_mode && !st_ff.mode.partial_idle_mode_run && !wr_cmd |=> $stable(st_ff.cnt);
    endproperty
    a_partial_idle_mode: assert property (p_partial_idle_mode) else $error("counter moved in partial idle"); // R18

    property p_count;
        running && !overflow && !wr_cmd |=> st_ff.cnt == $past(st_ff.cnt) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("counter did not advance"); // R1 R17

endmodule

// File: inc/rwdt_pkg.sv
// Constants and carrier types of the runaway watchdog
package rwdt_pkg;

    // ------------------------------------------------------------
    // Counter and detection taps
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = 22;
    localparam int unsigned TAP_EXP0 = 15;
    localparam int unsigned TAP_EXP1 = 17;
    localparam int unsigned TAP_EXP2 = 19;
    localparam int unsigned TAP_EXP3 = 21;

    // ------------------------------------------------------------
    // Register map: indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 14;
    localparam logic [11:0] IDX_MODE = 12'h300;
    localparam logic [11:0] IDX_CMD = 12'h301;
    localparam logic [11:0] IDX_STAT = 12'h302;
    localparam logic [13:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [13:0] ADDR_CMD = {IDX_CMD, 2'b00};
    localparam logic [13:0] ADDR_STAT = {IDX_STAT, 2'b00};

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_CLEAR = 8'h4E;
    localparam logic [7:0] CODE_DISABLE = 8'hB1;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned MODE_EN_BIT = 7;
    localparam int unsigned MODE_PSEL_LSB = 5;
    localparam int unsigned MODE_I2_BIT = 3;
    localparam int unsigned MODE_LINK_BIT = 1;
    localparam int unsigned STAT_RUN_BIT = 0;
    localparam int unsigned STAT_DIS_BIT = 1;
    localparam int unsigned STAT_RST_BIT = 2;
    localparam int unsigned STAT_BUS_RELEASE_ACK_BIT = 3;
    localparam int unsigned STAT_CNT_LSB = 10;
    localparam logic RST_EN = 1'b1;
    localparam logic [1:0] RST_PSEL = 2'h0;
    localparam logic RST_I2 = 1'b0;
    localparam logic RST_LINK = 1'b0;

    // ------------------------------------------------------------
    // Forced reset length
    // ------------------------------------------------------------
    localparam int unsigned PCLK_NS = 40;
    localparam int unsigned RESET_MIN_NS = 26100;
    localparam int unsigned RESET_CYCLES = (RESET_MIN_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int unsigned RST_CNT_W = 10;

    typedef struct packed {
        logic enable;
        logic [1:0] period_sel;
        logic partial_idle_mode_run;
        logic reset_link;
    } rwdt_mode_type;

    typedef struct packed {
        logic light_idle_mode;
        logic partial_idle_mode;
        logic stop_mode;
        logic bus_release_ack_n;
    } rwdt_power_type;

endpackage

// File: verilog/rwdt_reset_stretch.sv
// Stretches one overflow strobe into the forced reset pulse
`timescale 1ns/100ps
module rwdt_reset_stretch
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic pulse_out
);

    typedef struct packed {
        logic active;
        logic [rwdt_pkg::RST_CNT_W-1:0] cnt;
    } rwdt_stretch_type;

    localparam logic [rwdt_pkg::RST_CNT_W-1:0] LAST = (rwdt_pkg::RST_CNT_W)'(rwdt_pkg::RESET_CYCLES - 1);

    rwdt_stretch_type st_ff;
    rwdt_stretch_type nxt_st;
    logic [rwdt_pkg::RST_CNT_W-1:0] len_seen_ff;

    always_comb
    begin
        nxt_st = st_ff;
        if (st_ff.active)
        begin
            if (st_ff.cnt == LAST)
            begin
                nxt_st.active = 1'b0;
                nxt_st.cnt = '0;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
        else if (start)
        begin
            nxt_st.active = 1'b1;
            nxt_st.cnt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pulse_out = st_ff.active;

    // Helper: high cycles of the current pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            len_seen_ff <= '0;
        else if (st_ff.active)
            len_seen_ff <= len_seen_ff + 1'b1;
        else
            len_seen_ff <= '0;
    end

    property p_reset_len;
        @(posedge pclk) disable iff (!presetn)
        $fell(pulse_out) |-> len_seen_ff == (rwdt_pkg::RST_CNT_W)'(rwdt_pkg::RESET_CYCLES);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("forced reset length wrong"); // R15

endmodule

// File: dv/rwdt_runaway_detector_tb_top.sv
// Self-checking bench for the runaway watchdog
`timescale 1ns/100ps
module rwdt_runaway_detector_tb_top;
    // ------------------------------------------------------------
    // Clock, reset and design
    // ------------------------------------------------------------
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [rwdt_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rwdt_pkg::rwdt_power_type power;
    logic overflow_irq;
    logic internal_reset_req;
    int error_cnt;
    int num_checks;
    int cyc;
    logic [31:0] rd;
    logic err;
    logic [31:0] cur_mode;

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    // Short taps: periods of 8, 16, 32 and 64 cycles
    rwdt_runaway_detector #(.TAP_EXP0(3), .TAP_EXP1(4), .TAP_EXP2(5), .TAP_EXP3(6)) i_rwdt_runaway_detector
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power(power), .overflow_irq(overflow_irq), .internal_reset_req(internal_reset_req)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_count(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp)
        begin
            error_cnt++;
            $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits as long as the slave stretches; only the run watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    function automatic logic [31:0] mode_word(input logic en, input logic [1:0] sel, input logic i2, input logic lnk);
        mode_word = 32'h0;
        mode_word[rwdt_pkg::MODE_EN_BIT] = en;
        mode_word[rwdt_pkg::MODE_PSEL_LSB +: 2] = sel;
        mode_word[rwdt_pkg::MODE_I2_BIT] = i2;
        mode_word[rwdt_pkg::MODE_LINK_BIT] = lnk;
    endfunction

    task automatic cmd(input logic [7:0] code);
        apb(1'b1, rwdt_pkg::ADDR_CMD, {24'h0, code});
    endtask

    // Settings change only from the disabled state; ends with a clear
    task automatic cfg(input logic [1:0] sel, input logic i2, input logic lnk);
        apb(1'b1, rwdt_pkg::ADDR_MODE, cur_mode & ~(32'h1 << rwdt_pkg::MODE_EN_BIT));
        cmd(rwdt_pkg::CODE_CLEAR);
        cmd(rwdt_pkg::CODE_DISABLE);
        cur_mode = mode_word(1'b1, sel, i2, lnk);
        apb(1'b1, rwdt_pkg::ADDR_MODE, cur_mode);
        cmd(rwdt_pkg::CODE_CLEAR);
    endtask

    task automatic wait_irq(input int limit, output int n);
        int t0;
        t0 = cyc;
        n = -1;
        repeat (limit)
        begin
            @(posedge pclk);
            #1;
            if (overflow_irq === 1'b1)
            begin
                n = cyc - t0;
                break;
            end
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, rwdt_pkg::ADDR_MODE, 32'h0);
        chk_word(rd, 32'h0000_0080, "mode after reset");
        chk_word({31'h0, internal_reset_req}, 32'h0, "no forced reset");
        apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
        chk_word(rd & 32'hF, 32'h9, "running after reset");
        apb(1'b0, 14'h0000, 32'h0);
        chk_word({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_periods();
        int n;
        for (int s = 0; s < 4; s++)
        begin
            cfg(s[1:0], 1'b0, 1'b0);
            wait_irq(300, n);
            chk_count(n, 1 << (3 + s), "overflow period");
            @(posedge pclk);
            #1;
            chk_word({31'h0, overflow_irq}, 32'h0, "irq one cycle");
        end
        cfg(2'd2, 1'b0, 1'b0);
        repeat (20) @(posedge pclk);
        cmd(rwdt_pkg::CODE_CLEAR);
        wait_irq(300, n);
        chk_count(n, 32, "period after mid clear");
        $display("test periods done");
    endtask

    // Ignored codes, the disable code with enable still set among them
    task automatic t_other_codes();
        logic [7:0] codes [4] = '{8'h00, 8'hFF, 8'h4F, rwdt_pkg::CODE_DISABLE};
        int t0;
        int n;
        cfg(2'd1, 1'b0, 1'b0);
        t0 = cyc;
        foreach (codes[i]) cmd(codes[i]);
        n = cyc - t0;
        wait_irq(100, t0);
        chk_count(n + t0, 16, "other codes ignored");
        $display("test other codes done");
    endtask

    task automatic t_disable();
        logic [31:0] a;
        int n;
        apb(1'b1, rwdt_pkg::ADDR_MODE, cur_mode & ~(32'h1 << rwdt_pkg::MODE_EN_BIT));
        apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
        chk_word(rd & 32'h3, 32'h1, "enable bit alone keeps running");
        cmd(rwdt_pkg::CODE_CLEAR);
        cmd(rwdt_pkg::CODE_DISABLE);
        apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
        chk_word(rd & 32'h3, 32'h2, "disabled");
        a = rd >> rwdt_pkg::STAT_CNT_LSB;
        repeat (80) @(posedge pclk);
        apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
        chk_word(rd >> rwdt_pkg::STAT_CNT_LSB, a, "counter frozen");
        apb(1'b1, rwdt_pkg::ADDR_MODE, cur_mode);
        wait_irq(40, n);
        chk_count(n > 0, 1, "re-enabled by bit alone");
        $display("test disable done");
    endtask

    task automatic t_link();
        int n;
        int m;
        cfg(2'd0, 1'b0, 1'b1);
        wait_irq(100, n);
        chk_count(n, 8, "overflow with link");
        chk_word({31'h0, internal_reset_req}, 32'h1, "forced reset rises");
        m = 0;
        do
        begin
            @(posedge pclk);
            #1;
            m++;
        end while (internal_reset_req === 1'b1 && m < 2000);
        chk_count(m, rwdt_pkg::RESET_CYCLES, "forced reset length");
        cfg(2'd0, 1'b0, 1'b0);
        $display("test reset link done");
    endtask

    // Light idle, stop, partial idle without run bit halt; partial idle with it and bus release run
    task automatic t_power();
        logic [3:0] halt [3] = '{4'b1001, 4'b0011, 4'b0101};
        logic [3:0] run [2] = '{4'b0101, 4'b0000};
        logic [31:0] a;
        int n;
        cfg(2'd3, 1'b0, 1'b0);
        foreach (halt[i])
        begin
            @(posedge pclk);
            power <= rwdt_pkg::rwdt_power_type'(halt[i]);
            apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
            a = rd >> rwdt_pkg::STAT_CNT_LSB;
            repeat (100) @(posedge pclk);
            apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
            chk_word(rd >> rwdt_pkg::STAT_CNT_LSB, a, "halted in low power");
            @(posedge pclk);
            power <= rwdt_pkg::rwdt_power_type'(4'b0001);
        end
        cfg(2'd0, 1'b1, 1'b0);
        foreach (run[i])
        begin
            @(posedge pclk);
            power <= rwdt_pkg::rwdt_power_type'(run[i]);
            cmd(rwdt_pkg::CODE_CLEAR);
            wait_irq(100, n);
            chk_count(n, 8, "keeps counting");
        end
        @(posedge pclk);
        power <= rwdt_pkg::rwdt_power_type'(4'b0001);
        $display("test power done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        power = rwdt_pkg::rwdt_power_type'(4'b0001);
        error_cnt = 0;
        num_checks = 0;
        cyc = 0;
        cur_mode = 32'h0000_0080;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_periods();
        t_other_codes();
        t_disable();
        t_link();
        t_power();
        report_and_stop();
    end

    // Whole run needs well under 10000 cycles
    initial
    begin
        #(40 * 40000);
        error_cnt++;
        $display("BAD t=%0t run hung", $time);
        report_and_stop();
    end
endmodule
